/* File: bsl_blink.sv */
// free-running square wave with a half period set in clock cycles
`timescale 1ns/10ps
module bsl_blink #(
   parameter int HALF = 31250000,
   parameter int CW = 25
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic phase
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic ph;
   } bsl_blink_st_t;

   localparam logic [CW-1:0] LAST = CW'(HALF - 1);

   bsl_blink_st_t state_r;
   bsl_blink_st_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (state_r.cnt >= LAST) begin
         state_nxt.cnt = '0;
         state_nxt.ph = ~state_r.ph;
      end else begin
         state_nxt.cnt = state_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign phase = state_r.ph;
endmodule

/* File: bsl_led_driver.sv */
// bracket status indicator driver with an axi4-lite register slave
// Functional notes
// [RULE1] no firmware image loaded: board indicator solid red.
// [RULE2] normal image, gen3, eight lanes: board indicator solid green.
// [RULE3] normal image, gen1/gen2, eight lanes: board indicator flashing green.
// [RULE4] normal image, gen3, not eight lanes: board indicator solid yellow.
// [RULE5] normal image, gen1/gen2, not eight lanes: board indicator flashing yellow.
// [RULE6] safe image, gen3, any lane count: board indicator solid blue.
// [RULE7] safe image, gen1/gen2: board indicator flashing blue.
// [RULE8] pcie training failed: board indicator flashing red.
// [RULE9] camera indicator shows only the highest-priority active condition.
// [RULE10] camera attached, unpowered or software not ready: camera indicator off.
// [RULE11] camera incompatible: camera indicator flashes orange at about 2 hz.
// [RULE12] link not established or lost: camera indicator flashes green about 2 hz.
// [RULE13] camera link established: camera indicator steady green.
// [RULE14] acquisition running: camera indicator flashes green at about 4 hz.
// [RULE15] forwarding receiver, input link down: camera indicator flashes green.
// [RULE16] forwarding receiver, input link up: camera indicator steady green.
// [RULE17] downstream link not established: forwarding indicator off.
// [RULE18] downstream link established: forwarding indicator steady green.
// [RULE19] flashing at half duty from clock counters; all indicators off in reset.
`timescale 1ns/10ps
`include "bsl_params.svh"
module bsl_led_driver #(
   parameter int CLK_HZ = `BSL_CLK_HZ,
   parameter int MED_HALF = `BSL_CLK_HZ / (2 * `BSL_MED_FLASH_HZ),
   parameter int FAST_HALF = `BSL_CLK_HZ / (2 * `BSL_FAST_FLASH_HZ),
   parameter int CW = 25
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire bsl_pkg::bsl_stat_t stat_in,
   output bsl_pkg::bsl_leds_t leds,
   input wire logic [`BSL_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`BSL_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NBLINK = 2;
   localparam int MED_IDX = 0;
   localparam int FAST_IDX = 1;
   localparam int HALVES [NBLINK] = '{MED_HALF, FAST_HALF};

   bsl_pkg::bsl_core_t state_r;
   bsl_pkg::bsl_core_t state_nxt;
   bsl_pkg::bsl_stat_t st;
   logic [NBLINK-1:0] phase;
   bsl_pkg::bsl_reg_t wr_sel;
   bsl_pkg::bsl_reg_t rd_sel;

   // status levels come from other clock domains
   bsl_sync #(
      .WIDTH($bits(bsl_pkg::bsl_stat_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(stat_in),
      .q(st)
   );

   // [RULE19] counter-derived half-duty flashing
   generate
      for (genvar i = 0; i < NBLINK; i++) begin : g_blink
         bsl_blink #(
            .HALF(HALVES[i]),
            .CW(CW)
         ) u_blink (
            .aclk(aclk),
            .aresetn(aresetn),
            .phase(phase[i])
         );
      end
   endgenerate

   function automatic bsl_pkg::bsl_reg_t decode(input logic [`BSL_ADDR_W-1:0] a);
      bsl_pkg::bsl_reg_t r;
      r = bsl_pkg::BSL_REG_NONE;
      if (a == `BSL_CTRL_OFS) begin
         r = bsl_pkg::BSL_REG_CTRL;
      end else if (a == `BSL_STATUS_OFS) begin
         r = bsl_pkg::BSL_REG_STATUS;
      end
      return r;
   endfunction

   function automatic logic [1:0] resp_of(input bsl_pkg::bsl_reg_t r);
      logic [1:0] p;
      p = `BSL_RESP_OKAY;
      if (r == bsl_pkg::BSL_REG_NONE) begin
         // unmapped offsets answer a decode error
         p = `BSL_RESP_DECERR;
      end
      return p;
   endfunction

   function automatic logic full_width(input logic [4:0] lanes);
      logic f;
      f = (lanes == `BSL_FULL_LANES);
      return f;
   endfunction

   function automatic bsl_pkg::bsl_color_t flash(
      input bsl_pkg::bsl_color_t c,
      input logic ph
   );
      bsl_pkg::bsl_color_t r;
      r = ph ? c : bsl_pkg::BSL_OFF;
      return r;
   endfunction

   function automatic bsl_pkg::bsl_color_t board_color(
      input bsl_pkg::bsl_stat_t s,
      input logic ph
   );
      bsl_pkg::bsl_color_t c;
      bsl_pkg::bsl_color_t base;
      c = bsl_pkg::BSL_OFF;
      base = bsl_pkg::BSL_GREEN;
      if (!s.fw_loaded) begin
         // [RULE1] solid red, no image
         c = bsl_pkg::BSL_RED;
      end else if (s.pcie_fail) begin
         // [RULE8] flashing red on training failure
         c = flash(bsl_pkg::BSL_RED, ph);
      end else if (s.fw_safe) begin
         // [RULE6] safe image, gen3, lanes ignored
         if (s.pcie_gen3) begin
            c = bsl_pkg::BSL_BLUE;
         end else begin
            // [RULE7] safe image at lower speed
            c = flash(bsl_pkg::BSL_BLUE, ph);
         end
      end else begin
         if (full_width(s.pcie_lanes)) begin
            base = bsl_pkg::BSL_GREEN;
         end else begin
            base = bsl_pkg::BSL_YELLOW;
         end
         if (s.pcie_gen3) begin
            // [RULE2] [RULE4] solid at gen3
            c = base;
         end else begin
            // [RULE3] [RULE5] flashing below gen3
            c = flash(base, ph);
         end
      end
      return c;
   endfunction

   function automatic bsl_pkg::bsl_color_t cam_color(
      input bsl_pkg::bsl_stat_t s,
      input logic ready,
      input logic ph_med,
      input logic ph_fast
   );
      bsl_pkg::bsl_color_t c;
      c = bsl_pkg::BSL_OFF;
      // [RULE9] fixed priority, first match wins
      if (s.cam_attached) begin
         if (!s.cam_powered || !ready) begin
            // [RULE10] dark until powered and initialised
            c = bsl_pkg::BSL_OFF;
         end else if (s.cam_incompat) begin
            // [RULE11] orange medium flash
            c = flash(bsl_pkg::BSL_ORANGE, ph_med);
         end else if (!s.in_link_up) begin
            // [RULE12] green medium flash
            c = flash(bsl_pkg::BSL_GREEN, ph_med);
         end else if (s.acq_active) begin
            // [RULE14] green fast flash
            c = flash(bsl_pkg::BSL_GREEN, ph_fast);
         end else begin
            // [RULE13] steady green
            c = bsl_pkg::BSL_GREEN;
         end
      end else begin
         c = receiver_color(s, ready, ph_med);
      end
      return c;
   endfunction

   function automatic bsl_pkg::bsl_color_t receiver_color(
      input bsl_pkg::bsl_stat_t s,
      input logic ready,
      input logic ph_med
   );
      bsl_pkg::bsl_color_t c;
      c = bsl_pkg::BSL_OFF;
      if (!ready) begin
         // dark until software is ready
         c = bsl_pkg::BSL_OFF;
      end else if (!s.in_link_up) begin
         // [RULE15] receiver waiting for input link
         c = flash(bsl_pkg::BSL_GREEN, ph_med);
      end else begin
         // [RULE16] receiver link ready
         c = bsl_pkg::BSL_GREEN;
      end
      return c;
   endfunction

   function automatic logic [31:0] status_word(
      input bsl_pkg::bsl_leds_t l,
      input bsl_pkg::bsl_stat_t s
   );
      logic [31:0] w;
      w = 32'h00000000;
      w[`BSL_ST_BOARD_LSB +: 3] = l.board_status_indicator;
      w[`BSL_ST_CAM_LSB +: 3] = l.camera_link_indicator;
      w[`BSL_ST_FWD_LSB +: 3] = l.forward_link_indicator;
      w[`BSL_ST_IN_LSB +: $bits(bsl_pkg::bsl_stat_t)] = s;
      return w;
   endfunction

   function automatic logic [31:0] read_word(
      input bsl_pkg::bsl_reg_t r,
      input logic ready,
      input bsl_pkg::bsl_leds_t l,
      input bsl_pkg::bsl_stat_t s
   );
      logic [31:0] w;
      w = 32'h00000000;
      case (r)
         bsl_pkg::BSL_REG_CTRL: begin
            w[`BSL_CTRL_SWRDY_BIT] = ready;
         end
         bsl_pkg::BSL_REG_STATUS: begin
            w = status_word(l, s);
         end
         default: begin
            // unmapped reads return zero
            w = 32'h00000000;
         end
      endcase
      return w;
   endfunction

   function automatic bsl_pkg::bsl_color_t fwd_color(input logic up);
      bsl_pkg::bsl_color_t c;
      if (up) begin
         // [RULE18] downstream link up
         c = bsl_pkg::BSL_GREEN;
      end else begin
         // [RULE17] dark without downstream link
         c = bsl_pkg::BSL_OFF;
      end
      return c;
   endfunction

   // write handshakes follow the held-request flags, read ready follows rvalid
   assign s_axi_awready = !state_r.aw_got;
   assign s_axi_wready = !state_r.w_got;
   assign s_axi_arready = !state_r.rvalid;

   // one decode per channel
   assign wr_sel = decode(state_r.aw_addr);
   assign rd_sel = decode(s_axi_araddr);

   always_comb begin
      state_nxt = state_r;

      // write channel: address and data may arrive in either order
      if (s_axi_awvalid && !state_r.aw_got) begin
         state_nxt.aw_got = 1'b1;
         state_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_r.w_got) begin
         state_nxt.w_got = 1'b1;
         state_nxt.wdata = s_axi_wdata;
         state_nxt.wstrb = s_axi_wstrb;
      end
      if (state_r.bvalid && s_axi_bready) begin
         state_nxt.bvalid = 1'b0;
      end
      // commit waits for an idle response slot
      if (state_r.aw_got && state_r.w_got && !state_r.bvalid) begin
         state_nxt.aw_got = 1'b0;
         state_nxt.w_got = 1'b0;
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp = resp_of(wr_sel);
         case (wr_sel)
            bsl_pkg::BSL_REG_CTRL: begin
               if (state_r.wstrb[0]) begin
                  state_nxt.sw_ready = state_r.wdata[`BSL_CTRL_SWRDY_BIT];
               end
            end
            bsl_pkg::BSL_REG_STATUS: begin
               // read-only, write ignored
               state_nxt.sw_ready = state_r.sw_ready;
            end
            default: begin
               // unmapped, nothing stored
               state_nxt.sw_ready = state_r.sw_ready;
            end
         endcase
      end

      // read channel: one outstanding read
      if (state_r.rvalid && s_axi_rready) begin
         state_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !state_r.rvalid) begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rresp = resp_of(rd_sel);
         state_nxt.rdata = read_word(rd_sel, state_r.sw_ready, state_r.leds, st);
      end

      // indicator colours, one cycle after the synchronised status
      state_nxt.leds.board_status_indicator = board_color(st, phase[MED_IDX]);
      state_nxt.leds.camera_link_indicator =
         cam_color(st, state_r.sw_ready, phase[MED_IDX], phase[FAST_IDX]);
      state_nxt.leds.forward_link_indicator = fwd_color(st.fwd_link_up);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // [RULE19] indicators dark during reset
         state_r <= '0;
         state_r.sw_ready <= `BSL_CTRL_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign leds = state_r.leds;
   assign s_axi_bvalid = state_r.bvalid;
   assign s_axi_bresp = state_r.bresp;
   assign s_axi_rvalid = state_r.rvalid;
   assign s_axi_rdata = state_r.rdata;
   assign s_axi_rresp = state_r.rresp;
endmodule

/* File: bsl_led_monitor.sv */
// checker on the status indicator driver ports
`timescale 1ns/10ps
module bsl_led_monitor #(
   parameter int MED_HALF = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire bsl_pkg::bsl_stat_t stat_in,
   input wire bsl_pkg::bsl_leds_t leds,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   logic [2:0] stc_r;
   logic [15:0] run_r;
   logic [14:0] prev_r;
   logic [2:0] bprev_r;
   wire logic [2:0] bd = leds.board_status_indicator;
   // a change seen this edge has not reached the lamps yet
   wire logic ok = stc_r >= 3'h5 && stat_in == prev_r;
   wire logic nrm = stat_in.fw_loaded && !stat_in.fw_safe && !stat_in.pcie_fail;
   wire logic x8 = stat_in.pcie_lanes == 5'h08;
   wire logic g3 = stat_in.pcie_gen3;
   // settle and run counters; a status change restarts both, so the sync delay is covered
   always_ff @(posedge aclk) begin
      prev_r <= stat_in;
      bprev_r <= bd;
      if (!aresetn || stat_in != prev_r) stc_r <= 3'h0;
      else if (stc_r != 3'h7) stc_r <= stc_r + 3'h1;
      if (!aresetn || stat_in != prev_r || bd != bprev_r) run_r <= 16'h0;
      else run_r <= run_r + 16'h1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_NO_IMAGE: assert property (ok && !stat_in.fw_loaded |-> bd == bsl_pkg::BSL_RED)
      else $error("board indicator not solid red");
   AST_FULL_LINK: assert property (ok && nrm && g3 && x8 |-> bd == bsl_pkg::BSL_GREEN)
      else $error("board indicator not solid green");
   AST_NARROW: assert property (ok && nrm && g3 && !x8 |-> bd == bsl_pkg::BSL_YELLOW)
      else $error("board indicator not solid yellow");
   AST_SAFE_FAST: assert property (ok && stat_in.fw_loaded && stat_in.fw_safe && !stat_in.pcie_fail && g3
      |-> bd == bsl_pkg::BSL_BLUE) else $error("board indicator not solid blue");
   AST_SLOW_FLASH: assert property (ok && nrm && !g3 && x8
      |-> bd inside {bsl_pkg::BSL_OFF, bsl_pkg::BSL_GREEN} && run_r <= MED_HALF + 4)
      else $error("board indicator not flashing green");
   AST_TRAIN_FAIL: assert property (ok && stat_in.fw_loaded && stat_in.pcie_fail
      |-> bd inside {bsl_pkg::BSL_OFF, bsl_pkg::BSL_RED} && run_r <= MED_HALF + 4)
      else $error("board indicator not flashing red");
   AST_FWD_LINK: assert property (ok |-> leds.forward_link_indicator ==
      (stat_in.fwd_link_up ? bsl_pkg::BSL_GREEN : bsl_pkg::BSL_OFF)) else $error("forward indicator wrong");
   AST_RESET_DARK: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> leds == 9'h000)
      else $error("indicators lit in reset");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("write answer late");
   COV_SLOW: cover property (ok && nrm && !g3 && bd == bsl_pkg::BSL_GREEN);
   COV_FAIL: cover property (ok && stat_in.pcie_fail && bd == bsl_pkg::BSL_RED);
   COV_ORANGE: cover property (leds.camera_link_indicator == bsl_pkg::BSL_ORANGE);
endmodule

bind bsl_led_driver bsl_led_monitor #(.MED_HALF(MED_HALF)) bsl_led_monitor_inst (.aclk, .aresetn, .stat_in,
   .leds, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* File: bsl_led_panel.sv */
// bracket lamp model: counts colour changes of each lamp
`timescale 1ns/10ps
module bsl_led_panel (
   input wire logic aclk,
   input wire bsl_pkg::bsl_leds_t leds,
   output int flips [3]
);
   logic [8:0] last;
   initial begin
      last = 9'h000;
      flips = '{0, 0, 0};
   end
   // reads the pre-edge value, so no race with the driver
   always @(posedge aclk) begin
      for (int i = 0; i < 3; i++) if (leds[3*i +: 3] !== last[3*i +: 3]) flips[i]++;
      last = leds;
   end
endmodule

/* File: bsl_params.svh */
// offsets, reset values and timing figures for the status indicator driver
`ifndef BSL_PARAMS_SVH
`define BSL_PARAMS_SVH
`define BSL_ADDR_W 4
`define BSL_CTRL_OFS 4'h0
`define BSL_STATUS_OFS 4'h4
`define BSL_CTRL_SWRDY_BIT 0
`define BSL_CTRL_RST 1'b0
`define BSL_ST_BOARD_LSB 0
`define BSL_ST_CAM_LSB 4
`define BSL_ST_FWD_LSB 8
`define BSL_ST_IN_LSB 16
`define BSL_FULL_LANES 5'h08
`define BSL_CLK_HZ 125000000
`define BSL_MED_FLASH_HZ 2
`define BSL_FAST_FLASH_HZ 4
`define BSL_RESP_OKAY 2'h0
`define BSL_RESP_DECERR 2'h3
`endif

/* File: bsl_pkg.sv */
// types shared by the status indicator driver
package bsl_pkg;
   typedef enum logic [2:0] {
      BSL_OFF = 3'b000,
      BSL_RED = 3'b001,
      BSL_GREEN = 3'b010,
      BSL_YELLOW = 3'b011,
      BSL_BLUE = 3'b100,
      BSL_ORANGE = 3'b101
   } bsl_color_t;

   typedef enum logic [1:0] {
      BSL_REG_CTRL = 2'b00,
      BSL_REG_STATUS = 2'b01,
      BSL_REG_NONE = 2'b10
   } bsl_reg_t;

   typedef struct packed {
      logic fw_loaded;
      logic fw_safe;
      logic pcie_fail;
      logic pcie_gen3;
      logic [4:0] pcie_lanes;
      logic cam_attached;
      logic cam_powered;
      logic cam_incompat;
      logic in_link_up;
      logic acq_active;
      logic fwd_link_up;
   } bsl_stat_t;

   typedef struct packed {
      bsl_color_t board_status_indicator;
      bsl_color_t camera_link_indicator;
      bsl_color_t forward_link_indicator;
   } bsl_leds_t;

   typedef struct packed {
      logic aw_got;
      logic [3:0] aw_addr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sw_ready;
      bsl_leds_t leds;
   } bsl_core_t;
endpackage

/* File: bsl_sync.sv */
// two-stage synchroniser for a vector of quasi-static status levels
`timescale 1ns/10ps
module bsl_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } bsl_sync_st_t;

   bsl_sync_st_t state_r;
   bsl_sync_st_t state_nxt;

   always_comb begin
      state_nxt.s1 = d;
      state_nxt.s2 = state_r.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // only the second stage is visible
   assign q = state_r.s2;
endmodule

/* File: tb_top.sv */
// self-checking bench for the status indicator driver
`timescale 1ns/10ps
module tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   bsl_pkg::bsl_stat_t stat_in;
   bsl_pkg::bsl_leds_t leds;
   int flips [3];
   int n_fail, checks_done, cyc;
   // status, colours {board,camera,forward}, rates 0 solid 1 medium 2 fast
   logic [29:0] rows [9] = '{
      {15'h0000, 9'h050, 6'h04},
      {15'h4A35, 9'h092, 6'h00},
      {15'h423C, 9'h0A8, 6'h14},
      {15'h4930, 9'h0D0, 6'h04},
      {15'h4136, 9'h0D0, 6'h18},
      {15'h6910, 9'h110, 6'h04},
      {15'h6214, 9'h110, 6'h10},
      {15'h503A, 9'h068, 6'h14},
      {15'h0025, 9'h042, 6'h00}};
   bsl_led_driver #(.MED_HALF(8), .FAST_HALF(4)) bsl_led_driver_inst (.aclk, .aresetn, .stat_in, .leds,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   bsl_led_panel bsl_led_panel_inst (.aclk, .leds, .flips);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic finish_test();
      $display("mismatches %0d of %0d checks", n_fail, checks_done);
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ready is read at the falling edge, so the take never races the slave
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tb, pa, pw, pb;
      pa = 1;
      pw = 1;
      pb = 1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pb) begin
         @(negedge aclk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
         pb = !tb;
      end
   endtask
   task automatic rdt(input logic [3:0] a);
      logic ta, pa, pr;
      pa = 1;
      pr = 1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (pr) begin
         @(negedge aclk);
         ta = pa && s_axi_arready;
         pr = !s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (!pr) s_axi_rready <= 1'b0;
         pa = pa && !ta;
      end
   endtask
   // 64 cycles: solid lamps never change, medium about 8 changes, fast about 16
   task automatic watch(input logic [29:0] row);
      int f0 [3];
      int bad [3];
      int lo;
      for (int i = 0; i < 3; i++) begin
         f0[i] = flips[i];
         bad[i] = 0;
      end
      repeat (64) begin
         @(negedge aclk);
         for (int i = 0; i < 3; i++)
            if (!(leds[3*i +: 3] === row[6+3*i +: 3] || (row[2*i +: 2] != 0 && leds[3*i +: 3] === 3'h0))) bad[i]++;
      end
      for (int i = 0; i < 3; i++) begin
         lo = row[2*i +: 2] == 0 ? 0 : (row[2*i +: 2] == 1 ? 6 : 14);
         checks_done++;
         if (bad[i] != 0 || flips[i] - f0[i] < lo || flips[i] - f0[i] > lo + (lo == 0 ? 0 : 4)) begin
            n_fail++;
            $display("wrong value lamp %0d expected %h seen %0d changes", i, row[6+3*i +: 3], flips[i] - f0[i]);
         end
      end
   endtask
   initial begin
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      aresetn = 1'b0;
      stat_in = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      #1 chk("leds after reset", 0, leds);
      rdt(4'h0);
      chk("ctrl reset", 0, rd);
      stat_in <= rows[1][29:15];
      repeat (8) @(posedge aclk);
      #1 chk("camera before ready", 0, leds.camera_link_indicator);
      wr(4'h0, 32'h0000_0001);
      chk("ctrl bresp", 0, rs);
      rdt(4'h4);
      chk("status board", 2, rd[2:0]);
      chk("status forward", 2, rd[10:8]);
      chk("status camera", 2, rd[6:4]);
      chk("status inputs", rows[1][29:15], rd[30:16]);
      wr(4'h8, 32'h0000_0001);
      chk("unmapped bresp", 3, rs);
      rdt(4'hC);
      chk("unmapped rresp", 3, rs);
      chk("unmapped rdata", 0, rd);
      s_axi_wstrb <= 4'h0;
      wr(4'h0, 32'h0000_0000);
      chk("masked bresp", 0, rs);
      s_axi_wstrb <= 4'hF;
      rdt(4'h0);
      chk("ctrl masked write", 1, rd);
      foreach (rows[i]) begin
         @(posedge aclk);
         stat_in <= rows[i][29:15];
         repeat (8) @(posedge aclk);
         watch(rows[i]);
      end
      @(posedge aclk);
      aresetn <= 1'b0;
      stat_in <= rows[1][29:15];
      repeat (4) @(posedge aclk);
      #1 chk("leds in reset", 0, leds);
      @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
      #1 chk("camera after reset", 0, leds.camera_link_indicator);
      chk("board after reset", 2, leds.board_status_indicator);
      finish_test();
   end
endmodule
